// File: core/bdr_pkg.sv
// Constants, types and threshold tables for the boost duty regulator
package bdr_pkg;

  // ---------------------------------------------------------------------
  // Duty code and PWM period
  // ---------------------------------------------------------------------
  localparam logic [5:0] DUTY_FULL       = 6'h3f;
  localparam logic [5:0] MIN_DUTY_FLOOR  = 6'h04;
  localparam logic [5:0] MAX_DUTY_CAP    = 6'h3d;
  localparam logic [5:0] DUTY_OFF        = 6'h00;
  localparam logic [5:0] PWM_LAST        = 6'h3f;
  localparam logic [1:0] STEP_WIN1       = 2'h1;
  localparam logic [1:0] STEP_WIN2       = 2'h2;
  localparam logic [1:0] STEP_WIN3       = 2'h2;
  localparam int         CTRL_INTERVAL_DEF = 4;

  // ---------------------------------------------------------------------
  // Sample scaling and battery bands
  // ---------------------------------------------------------------------
  localparam int ADC_FS_CODE = 255;
  localparam int BAT_FS_V    = 40;
  localparam int BOOST_FS_V  = 80;
  localparam int BAND_EDGE_V [0:6] = '{5, 10, 16, 20, 24, 30, 35};
  // Higher battery band, lower ceiling
  localparam logic [5:0] MAX_DUTY_TABLE [0:7] =
    '{6'h3d, 6'h3a, 6'h36, 6'h32, 6'h2e, 6'h2a, 6'h26, 6'h22};

  // Volts to the first code at or above that level
  function automatic logic [7:0] bdr_volt_to_code(input int v,
                                                  input int fs);
    return 8'((v * ADC_FS_CODE + fs - 1) / fs);
  endfunction

  // ---------------------------------------------------------------------
  // Boost windows per range, in volts around the target
  // ---------------------------------------------------------------------
  localparam int TARGET_BASE_V = 20;
  localparam int TARGET_STEP_V = 3;
  localparam int WIN0_HALF_V   = 1;
  localparam int WIN1_HALF_V   = 5;
  localparam int WIN2_HALF_V   = 8;
  localparam int SHUT_ABOVE_V  = 12;

  typedef struct packed {
    logic [7:0] w2_lo;
    logic [7:0] w1_lo;
    logic [7:0] w0_lo;
    logic [7:0] w0_hi;
    logic [7:0] w1_hi;
    logic [7:0] w2_hi;
    logic [7:0] shut;
  } bdr_thresh_t;

  function automatic bdr_thresh_t bdr_thresholds(input logic [3:0] rng);
    int t;
    bdr_thresh_t th;
    t        = TARGET_BASE_V + TARGET_STEP_V * int'(rng);
    th.w2_lo = bdr_volt_to_code(t - WIN2_HALF_V, BOOST_FS_V);
    th.w1_lo = bdr_volt_to_code(t - WIN1_HALF_V, BOOST_FS_V);
    th.w0_lo = bdr_volt_to_code(t - WIN0_HALF_V, BOOST_FS_V);
    th.w0_hi = bdr_volt_to_code(t + WIN0_HALF_V, BOOST_FS_V);
    th.w1_hi = bdr_volt_to_code(t + WIN1_HALF_V, BOOST_FS_V);
    th.w2_hi = bdr_volt_to_code(t + WIN2_HALF_V, BOOST_FS_V);
    th.shut  = bdr_volt_to_code(t + SHUT_ABOVE_V, BOOST_FS_V);
    return th;
  endfunction

  typedef enum logic [2:0] {
    Z_LO3, Z_LO2, Z_LO1, Z_WIN0, Z_HI1, Z_HI2, Z_HI3, Z_SHUT
  } bdr_zone_t;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_SAMPLES   = 8'h08;
  localparam int         CTRL_RANGE_LSB = 0;
  localparam int         CTRL_FREQ_LSB  = 4;
  localparam int         CTRL_DIS_BIT   = 8;
  localparam logic [3:0] RANGE_RST      = 4'h0;
  localparam logic [2:0] FREQ_RST       = 3'h0;
  localparam logic       DIS_RST        = 1'b1;
  localparam int         ST_DUTY_LSB    = 0;
  localparam int         ST_BAND_LSB    = 8;
  localparam int         ST_ZONE_LSB    = 12;
  localparam int         ST_SHUT_BIT    = 16;
  localparam int         ST_GATE_BIT    = 17;
  localparam int         SMP_BOOST_LSB  = 0;
  localparam int         SMP_BATT_LSB   = 8;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } bdr_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bdr_axi_rsp_t;

endpackage

// File: core/bdr_window_class.sv
// Sorts one boost sample into its regulation window for the chosen range
`timescale 1ns/1ps
module bdr_window_class (
  // Sample and range
  input  wire logic [7:0]        sample,
  input  wire logic [3:0]        range_sel,
  // Result
  output bdr_pkg::bdr_zone_t     zone
);
  import bdr_pkg::*;

  bdr_thresh_t th;

  // Constant table per range, picked by the range code
  assign th = bdr_thresholds(range_sel);

  // Shutdown checked first so it always wins
  always_comb begin
    if (sample >= th.shut) begin
      zone = Z_SHUT;
    end else if (sample > th.w2_hi) begin
      zone = Z_HI3;
    end else if (sample > th.w1_hi) begin
      zone = Z_HI2;
    end else if (sample > th.w0_hi) begin
      zone = Z_HI1;
    end else if (sample >= th.w0_lo) begin
      zone = Z_WIN0;
    end else if (sample >= th.w1_lo) begin
      zone = Z_LO1;
    end else if (sample >= th.w2_lo) begin
      zone = Z_LO2;
    end else begin
      zone = Z_LO3;
    end
  end

endmodule

// File: core/bdr_regulator.sv
// Boost duty regulator: window control law, PWM gate and AXI4-Lite regs
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

module bdr_regulator #(
  parameter int CTRL_INTERVAL = bdr_pkg::CTRL_INTERVAL_DEF
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // Converter samples
  input  wire logic                  boost_sample_valid,
  input  wire logic [7:0]            boost_sample,
  input  wire logic                  battery_sample_valid,
  input  wire logic [7:0]            battery_sample,
  // Register bus
  input  wire bdr_pkg::bdr_axi_req_t axi_req,
  output bdr_pkg::bdr_axi_rsp_t      axi_rsp,
  // Pre-driver and observation
  output logic                       boost_gate_drive,
  output logic [5:0]                 duty_code
);
  import bdr_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  range_sel;
    logic [2:0]  freq_sel;
    logic        dis;
    logic [2:0]  pre_cnt;
    logic [5:0]  pwm_cnt;
    logic [7:0]  ivl_cnt;
    logic        fast_ph;
    logic [5:0]  duty;
    logic        gate;
    logic [7:0]  boost_smp;
    logic [7:0]  batt_smp;
    logic [2:0]  band;
    logic        aw_done;
    logic        w_done;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    bdr_axi_rsp_t rsp;
  } bdr_state_t;

  localparam bdr_state_t ST_RST = '{
    range_sel: RANGE_RST, freq_sel: FREQ_RST, dis: DIS_RST,
    pre_cnt: 3'h0, pwm_cnt: 6'h00, ivl_cnt: 8'h00, fast_ph: 1'b0,
    duty: DUTY_OFF, gate: 1'b0, boost_smp: 8'h00, batt_smp: 8'h00,
    band: 3'h0, aw_done: 1'b0, w_done: 1'b0, awaddr: 8'h00,
    wdata: 32'h0000_0000, wstrb: 4'h0,
    rsp: '{awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: RESP_OKAY,
           arready: 1'b1, rvalid: 1'b0, rdata: 32'h0000_0000,
           rresp: RESP_OKAY}
  };

  bdr_state_t st_reg;
  bdr_state_t st_next;
  bdr_zone_t  zone;
  logic       pre_tick;
  logic       period_end;
  logic       norm_upd;
  logic       fast_upd;
  logic       shut;
  logic [5:0] max_limit;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] smp_word;

  // ---------------------------------------------------------------------
  // Window classification and timing strobes
  // ---------------------------------------------------------------------
  // Boost sample alone picks the control action
  bdr_window_class u_class (
    .sample    (st_reg.boost_smp),
    .range_sel (st_reg.range_sel),
    .zone      (zone)
  );

  // Prescaler stretches each PWM step; period stays 64 steps
  assign pre_tick   = (st_reg.pre_cnt == st_reg.freq_sel);
  assign period_end = pre_tick && (st_reg.pwm_cnt == PWM_LAST);
  assign norm_upd   = period_end &&
                      (st_reg.ivl_cnt == 8'(CTRL_INTERVAL - 1));
  assign fast_upd   = period_end && st_reg.fast_ph;
  assign shut       = (zone == Z_SHUT);
  // Battery only feeds the ceiling lookup
  assign max_limit  = MAX_DUTY_TABLE[st_reg.band];

  // Register read images
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[CTRL_RANGE_LSB +: 4] = st_reg.range_sel;
    ctrl_word[CTRL_FREQ_LSB +: 3]  = st_reg.freq_sel;
    ctrl_word[CTRL_DIS_BIT]        = st_reg.dis;
    status_word = 32'h0000_0000;
    status_word[ST_DUTY_LSB +: 6]  = st_reg.duty;
    status_word[ST_BAND_LSB +: 3]  = st_reg.band;
    status_word[ST_ZONE_LSB +: 3]  = zone;
    status_word[ST_SHUT_BIT]       = shut;
    status_word[ST_GATE_BIT]       = st_reg.gate;
    smp_word = 32'h0000_0000;
    smp_word[SMP_BOOST_LSB +: 8]   = st_reg.boost_smp;
    smp_word[SMP_BATT_LSB +: 8]    = st_reg.batt_smp;
  end

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    logic [1:0]  step;
    logic        up;
    logic [6:0]  sum;
    logic [5:0]  cand;
    logic [31:0] cw;
    st_next = st_reg;
    step    = 2'h0;
    up      = 1'b0;
    sum     = 7'h00;
    cand    = 6'h00;
    cw      = ctrl_word;

    // PWM counter; wraps after 64 steps so period stays 64 steps
    st_next.pre_cnt = pre_tick ? 3'h0 : 3'(st_reg.pre_cnt + 3'h1);
    if (pre_tick) begin
      st_next.pwm_cnt = 6'(st_reg.pwm_cnt + 6'h01);
    end
    if (period_end) begin
      st_next.ivl_cnt = norm_upd ? 8'h00 : 8'(st_reg.ivl_cnt + 8'h01);
      st_next.fast_ph = ~st_reg.fast_ph;
    end

    // Latest samples
    if (boost_sample_valid) begin
      st_next.boost_smp = boost_sample;
    end
    if (battery_sample_valid) begin
      st_next.batt_smp = battery_sample;
    end

    // Band = number of band edges at or below the sample
    st_next.band = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (st_reg.batt_smp >=
          bdr_volt_to_code(BAND_EDGE_V[i], BAT_FS_V)) begin
        st_next.band = 3'(i + 1);
      end
    end

    // Control law: step size and direction per window
    case (zone)
      Z_WIN0: step = 2'h0;
      Z_HI1: step = norm_upd ? STEP_WIN1 : 2'h0;
      Z_LO1: begin
        step = norm_upd ? STEP_WIN1 : 2'h0;
        up   = 1'b1;
      end
      Z_HI2: step = norm_upd ? STEP_WIN2 : 2'h0;
      Z_LO2: begin
        step = norm_upd ? STEP_WIN2 : 2'h0;
        up   = 1'b1;
      end
      Z_HI3: step = fast_upd ? STEP_WIN3 : 2'h0;
      Z_LO3: begin
        step = fast_upd ? STEP_WIN3 : 2'h0;
        up   = 1'b1;
      end
      default: step = 2'h0;
    endcase

    // Apply step, then clamp into floor..ceiling
    sum = {1'b0, st_reg.duty} + {5'h00, step};
    if (up) begin
      cand = sum[6] ? DUTY_FULL : sum[5:0];
    end else begin
      cand = (st_reg.duty > {4'h0, step}) ?
             6'(st_reg.duty - {4'h0, step}) : 6'h00;
    end
    if (cand < MIN_DUTY_FLOOR) begin
      cand = MIN_DUTY_FLOOR;
    end
    if (cand > max_limit) begin
      cand = max_limit;
    end
    // Disable and shutdown both take the gate to zero duty
    if (st_reg.dis || shut) begin
      st_next.duty = DUTY_OFF;
    end else begin
      st_next.duty = cand;
    end

    // Gate high while the counter is below the duty code
    st_next.gate = !st_reg.dis && !shut &&
                   (st_next.pwm_cnt < st_next.duty);

    // AXI4-Lite write: address and data in either order
    if (st_reg.rsp.awready && axi_req.awvalid) begin
      st_next.awaddr      = axi_req.awaddr;
      st_next.aw_done     = 1'b1;
      st_next.rsp.awready = 1'b0;
    end
    if (st_reg.rsp.wready && axi_req.wvalid) begin
      st_next.wdata      = axi_req.wdata;
      st_next.wstrb      = axi_req.wstrb;
      st_next.w_done     = 1'b1;
      st_next.rsp.wready = 1'b0;
    end
    if (st_reg.aw_done && st_reg.w_done && !st_reg.rsp.bvalid) begin
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp  = RESP_OKAY;
      case (st_reg.awaddr)
        ADDR_CTRL: begin
          for (int b = 0; b < 4; b++) begin
            if (st_reg.wstrb[b]) begin
              cw[8*b +: 8] = st_reg.wdata[8*b +: 8];
            end
          end
          st_next.range_sel = cw[CTRL_RANGE_LSB +: 4];
          st_next.freq_sel  = cw[CTRL_FREQ_LSB +: 3];
          st_next.dis       = cw[CTRL_DIS_BIT];
        end
        ADDR_STATUS, ADDR_SAMPLES: st_next.rsp.bresp = RESP_OKAY;
        default: st_next.rsp.bresp = RESP_SLVERR;
      endcase
    end
    if (st_reg.rsp.bvalid && axi_req.bready) begin
      st_next.rsp.bvalid  = 1'b0;
      st_next.aw_done     = 1'b0;
      st_next.w_done      = 1'b0;
      st_next.rsp.awready = 1'b1;
      st_next.rsp.wready  = 1'b1;
    end

    // AXI4-Lite read: one outstanding, data captured at acceptance
    if (st_reg.rsp.arready && axi_req.arvalid) begin
      st_next.rsp.arready = 1'b0;
      st_next.rsp.rvalid  = 1'b1;
      st_next.rsp.rresp   = RESP_OKAY;
      case (axi_req.araddr)
        ADDR_CTRL:    st_next.rsp.rdata = ctrl_word;
        ADDR_STATUS:  st_next.rsp.rdata = status_word;
        ADDR_SAMPLES: st_next.rsp.rdata = smp_word;
        default: begin
          st_next.rsp.rdata = 32'h0000_0000;
          st_next.rsp.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.rsp.rvalid && axi_req.rready) begin
      st_next.rsp.rvalid  = 1'b0;
      st_next.rsp.arready = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops
  assign axi_rsp          = st_reg.rsp;
  assign boost_gate_drive = st_reg.gate;
  assign duty_code        = st_reg.duty;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_duty_not_full: assert property (duty_code != DUTY_FULL)
    else $error("duty code reached full on-time");

  a_duty_cap_61: assert property (duty_code <= MAX_DUTY_CAP)
    else $error("duty code above absolute ceiling");

  a_duty_floor: assert property (
    !st_reg.dis && !shut |=> duty_code >= MIN_DUTY_FLOOR)
    else $error("duty code below floor while running");

  a_clamp_band: assert property (
    !st_reg.dis && !shut |=> duty_code <= $past(max_limit))
    else $error("duty code above battery ceiling");

  a_shut_zero: assert property (
    shut |=> duty_code == DUTY_OFF && !boost_gate_drive)
    else $error("shutdown did not clear duty and gate");

  a_disable_off: assert property (
    st_reg.dis |=> !boost_gate_drive && duty_code == DUTY_OFF)
    else $error("gate driven while disabled");

  a_win0_hold: assert property (
    zone == Z_WIN0 && !st_reg.dis && duty_code >= MIN_DUTY_FLOOR &&
    duty_code <= max_limit |=> $stable(duty_code))
    else $error("duty changed inside the centre window");

  a_win1_step: assert property (
    zone == Z_LO1 && norm_upd && !st_reg.dis &&
    duty_code >= MIN_DUTY_FLOOR && duty_code < max_limit
    |=> duty_code == $past(duty_code) + 6'h01)
    else $error("normal window did not step by one");

  a_win2_step: assert property (
    zone == Z_HI2 && norm_upd && !st_reg.dis &&
    duty_code >= 6'(MIN_DUTY_FLOOR + 6'h02) && duty_code <= max_limit
    |=> duty_code == $past(duty_code) - 6'h02)
    else $error("second window did not step by two");

  a_no_mid_step: assert property (
    (zone == Z_HI1 || zone == Z_LO1) && !norm_upd && !st_reg.dis &&
    duty_code >= MIN_DUTY_FLOOR && duty_code <= max_limit
    |=> $stable(duty_code))
    else $error("duty moved between control intervals");

  a_band_top: assert property (
    battery_sample_valid && battery_sample >= 8'he0
    |=> ##1 st_reg.band == 3'h7)
    else $error("full-scale battery not in top band");

  a_pwm_wrap: assert property (
    period_end |=> st_reg.pwm_cnt == 6'h00)
    else $error("PWM period not 64 steps");

  c_shutdown: cover property (shut ##1 duty_code == DUTY_OFF);
  c_step_up:  cover property (zone == Z_LO1 && norm_upd);
  c_fast_dn:  cover property (zone == Z_HI3 && fast_upd);
  c_write:    cover property (axi_rsp.bvalid && axi_req.bready);

endmodule

// File: verification/bdr_adc_model.sv
// ADC sampling model that feeds boost and battery codes to the regulator
`timescale 1ns/1ps
module bdr_adc_model #(
  parameter int GAP = 16
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Analog levels, already as codes
  input  wire logic [7:0] boost_level,
  input  wire logic [7:0] battery_level,
  // Sample strobes and codes
  output logic            boost_valid,
  output logic [7:0]      boost_code,
  output logic            battery_valid,
  output logic [7:0]      battery_code
);
  logic [7:0] cnt;

  // Free-running slots; codes are inverted junk between strobes so that
  // sampling outside a strobe shows up as a wrong window
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt           <= 8'h00;
      boost_valid   <= 1'b0;
      boost_code    <= 8'h00;
      battery_valid <= 1'b0;
      battery_code  <= 8'h00;
    end else begin
      cnt           <= (cnt == 8'(GAP - 1)) ? 8'h00 : cnt + 8'h01;
      boost_valid   <= (cnt == 8'h00);
      boost_code    <= (cnt == 8'h00) ? boost_level : ~boost_level;
      battery_valid <= (cnt == 8'(GAP / 2));
      battery_code  <= (cnt == 8'(GAP / 2)) ? battery_level : ~battery_level;
    end
  end
endmodule

// File: verification/boost_duty_regulator_test.sv
// Self-checking bench for the boost duty regulator
`timescale 1ns/1ps
module boost_duty_regulator_test;
  import bdr_pkg::*;
  logic         clk;
  logic         resetn;
  logic [7:0]   bst_lvl;
  logic [7:0]   bat_lvl;
  logic         bst_v;
  logic [7:0]   bst;
  logic         bat_v;
  logic [7:0]   bat;
  bdr_axi_req_t req;
  bdr_axi_rsp_t rsp;
  logic         gate;
  logic [5:0]   duty;
  logic [5:0]   d;
  logic [31:0]  rd;
  logic [1:0]   rs;
  int           error_cnt;
  int           n_tests;
  int           i;
  logic [7:0]   zs [0:7] = '{8'h1e, 8'h2c, 8'h37, 8'h40,
                             8'h48, 8'h55, 8'h5f, 8'h6e};
  logic [7:0]   bs [0:3] = '{8'h1f, 8'h20, 8'hdf, 8'he0};
  int           bb [0:3] = '{0, 1, 6, 7};

  // -------------------------------------------------------------------
  // Design and sample source
  // -------------------------------------------------------------------
  bdr_regulator #(.CTRL_INTERVAL(1)) uut (
    .clk(clk), .resetn(resetn),
    .boost_sample_valid(bst_v), .boost_sample(bst),
    .battery_sample_valid(bat_v), .battery_sample(bat),
    .axi_req(req), .axi_rsp(rsp),
    .boost_gate_drive(gate), .duty_code(duty));

  bdr_adc_model #(.GAP(16)) adc (
    .clk(clk), .resetn(resetn),
    .boost_level(bst_lvl), .battery_level(bat_lvl),
    .boost_valid(bst_v), .boost_code(bst),
    .battery_valid(bat_v), .battery_code(bat));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One write; leading edge keeps strobes from being set twice at once
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge clk);
    req.awaddr  <= a;
    req.wdata   <= v;
    req.wstrb   <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
      if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        rs = rsp.bresp;
        req.bready <= 1'b0;
        k = 99;
      end
    end
    if (k == 50) error_cnt++;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int k;
    @(posedge clk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        rd = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
        k = 99;
      end
    end
    if (k == 50) error_cnt++;
  endtask

  // New levels, then enough time for a few strobes to land
  task automatic lvl(input logic [7:0] b, input logic [7:0] v);
    @(posedge clk);
    bst_lvl <= b;
    bat_lvl <= v;
    tick(40);
    #1;
  endtask

  task automatic wait_chg(output int n);
    logic [5:0] s;
    s = duty;
    for (n = 1; n < 1000; n++) begin
      @(posedge clk);
      #1;
      if (duty !== s) break;
    end
  endtask

  // Size of one duty step and the clocks between two steps
  task automatic step(input logic [5:0] dlt, input int gap);
    logic [5:0] d0;
    logic [5:0] dd;
    int         n;
    wait_chg(n);
    d0 = duty;
    wait_chg(n);
    dd = duty - d0;
    check(32'(dd), 32'(dlt));
    check(n, gap);
  endtask

  task automatic gate_cnt(input logic [5:0] exp);
    int c;
    c = 0;
    repeat (64) begin
      @(posedge clk);
      #1;
      if (gate === 1'b1) c++;
    end
    check(c, 32'(exp));
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog, well beyond the expected run of some 7k clocks
  initial begin
    tick(30000);
    error_cnt++;
    final_report;
  end

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    error_cnt = 0;
    n_tests   = 0;
    resetn    = 1'b0;
    req       = '0;
    bst_lvl   = 8'h40;
    bat_lvl   = 8'h0a;
    tick(12);
    resetn <= 1'b1;
    axi_rd(ADDR_CTRL);
    check(rd, 32'h100);
    #1;
    check(32'(duty), 32'h0);
    axi_rd(8'h40);
    check(32'(rs), 32'(RESP_SLVERR));
    check(rd, 32'h0);
    axi_wr(8'h40, 32'h0);
    check(32'(rs), 32'(RESP_SLVERR));
    axi_wr(ADDR_CTRL, 32'h0);
    check(32'(rs), 32'(RESP_OKAY));
    // Status is read-only: write answers OKAY and leaves control alone
    axi_wr(ADDR_STATUS, 32'hffff_ffff);
    check(32'(rs), 32'(RESP_OKAY));
    axi_rd(ADDR_CTRL);
    check(rd, 32'h0);
    lvl(8'h40, 8'h0a);
    check(32'(duty), 32'h4);
    gate_cnt(6'h04);
    // Every window of range 0, ending in shutdown
    for (i = 0; i < 8; i++) begin
      lvl(zs[i], 8'h0a);
      axi_rd(ADDR_STATUS);
      check(32'(rd[14:12]), i);
    end
    #1;
    check(32'(duty), 32'h0);
    check(32'(rd[16]), 32'h1);
    axi_rd(ADDR_SAMPLES);
    check(32'(rs), 32'(RESP_OKAY));
    check(32'(rd[15:0]), 32'h0a6e);
    // Band edges either side of two boundaries
    for (i = 0; i < 4; i++) begin
      lvl(8'h40, bs[i]);
      axi_rd(ADDR_STATUS);
      check(32'(rd[10:8]), bb[i]);
    end
    #1;
    check(32'(duty), 32'h4);
    lvl(8'h37, 8'h0a);
    step(6'h01, 64);
    lvl(8'h2c, 8'h0a);
    step(6'h02, 64);
    lvl(8'h1e, 8'h0a);
    step(6'h02, 128);
    tick(4000);
    #1;
    check(32'(duty), 32'h3d);
    lvl(8'h1e, 8'hfa);
    check(32'(duty), 32'h22);
    lvl(8'h48, 8'hfa);
    step(6'h3f, 64);
    lvl(8'h55, 8'hfa);
    step(6'h3e, 64);
    lvl(8'h5f, 8'hfa);
    step(6'h3e, 128);
    // Window 0 holds while the battery falls and its ceiling rises
    lvl(8'h40, 8'hfa);
    d = duty;
    lvl(8'h40, 8'h0a);
    tick(300);
    #1;
    check(32'(duty), 32'(d));
    gate_cnt(d);
    axi_wr(ADDR_CTRL, 32'h10);
    lvl(8'h48, 8'h0a);
    step(6'h3f, 128);
    axi_wr(ADDR_CTRL, 32'h1);
    lvl(8'h40, 8'h0a);
    axi_rd(ADDR_STATUS);
    check(32'(rd[14:12]), 32'h2);
    axi_wr(ADDR_CTRL, 32'h100);
    tick(4);
    #1;
    check(32'(duty), 32'h0);
    gate_cnt(6'h00);
    final_report;
  end
endmodule
